/* verilog/trip_pkg.sv */
// Package of constants, register map and types for the trip log block
package trip_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int LOG_DEPTH   = 10;
    localparam int CODE_W      = 8;
    localparam int STAMP_W     = 32;

    // ****************************************************************
    // Trip codes of the trip classes that steer the response
    // ****************************************************************
    localparam logic [7:0] CODE_UNDERVOLTAGE  = 8'h01;
    localparam logic [7:0] CODE_BUS_HIGH_V    = 8'h02;
    localparam logic [7:0] CODE_OUT_OVERLOAD  = 8'h14;
    localparam logic [7:0] CODE_BRAKE_OVERCUR = 8'h04;
    localparam logic [7:0] CODE_POWER_STAGE   = 8'h05;
    localparam logic [7:0] CODE_BRAKE_THERMAL = 8'h13;
    localparam logic [7:0] CODE_AUX_SUPPLY    = 8'h09;
    localparam logic [7:0] CODE_PROGRAM_LO    = 8'h28;
    localparam logic [7:0] CODE_PROGRAM_HI    = 8'h2B;
    localparam logic [7:0] CODE_HW_FAULT_LO   = 8'hC8;
    localparam logic [7:0] CODE_HW_FAULT_HI   = 8'hDB;
    localparam logic [7:0] CODE_MOTOR_OVERLD  = 8'h15;
    localparam logic [7:0] CODE_MOTOR_THERMAL = 8'h18;

    // ****************************************************************
    // Overload threshold, percent of full-load current
    // ****************************************************************
    localparam logic [7:0] OVL_DEFAULT_OPEN   = 8'h71;
    localparam logic [7:0] OVL_DEFAULT_CLOSED = 8'h72;
    localparam logic [7:0] OVL_LIMIT          = 8'h96;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
    localparam logic [7:0] OFS_OVL       = 8'h14;
    localparam logic [7:0] OFS_CODE0     = 8'h40;
    localparam logic [7:0] OFS_DATE0     = 8'h80;
    localparam logic [7:0] OFS_TIME0     = 8'hC0;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_STAMP_SEL  = 0;
    localparam int CTRL_TSRC_LSB   = 1;
    localparam int CTRL_CLOSED     = 3;
    localparam int CTRL_TRIP_CLR   = 4;
    localparam int CTRL_LV_SUPPLY  = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Interrupt bits
    localparam int IRQ_TRIP   = 0;
    localparam int IRQ_CLEAR  = 1;
    localparam int IRQ_FIRE   = 2;
    localparam int IRQ_W      = 3;

    // Time sources
    localparam logic [1:0] TSRC_POWERUP = 2'h0;
    localparam logic [1:0] TSRC_RUNNING = 2'h1;
    localparam logic [1:0] TSRC_RTC     = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [CODE_W-1:0]  code;
        logic [STAMP_W-1:0] date_or_zero;
        logic [STAMP_W-1:0] time_or_module;
    } log_entry_t;

    typedef struct packed {
        logic [STAMP_W-1:0] powerup;
        logic [STAMP_W-1:0] running;
        logic [STAMP_W-1:0] rtc_time;
        logic [STAMP_W-1:0] rtc_date;
    } time_base_t;

endpackage

/* verilog/trip_log_mem.sv */
// Ten-entry trip history shift log
`timescale 1ns/1ps
module trip_log_mem
    import trip_pkg::*;
#(
    parameter int DEPTH = LOG_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        push,
    input  log_entry_t       new_entry,
    input  wire logic [3:0]  rd_idx,
    output log_entry_t       rd_entry
);

    log_entry_t entry_q [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_slot
            if (g == 0) begin : g_head
                always_ff @(posedge clk or negedge reset_n) begin
                    if (!reset_n) begin
                        entry_q[g] <= '0;
                    end else if (push) begin
                        entry_q[g] <= new_entry;
                    end
                end
            end else begin : g_tail
                always_ff @(posedge clk or negedge reset_n) begin
                    if (!reset_n) begin
                        entry_q[g] <= '0;
                    end else if (push) begin
                        entry_q[g] <= entry_q[g-1];
                    end
                end
            end
        end
    endgenerate

    always_comb begin
        if (32'(rd_idx) < DEPTH) begin
            rd_entry = entry_q[rd_idx];
        end else begin
            rd_entry = '0;
        end
    end

    a_push_shift: assert property (
        @(posedge clk) disable iff (!reset_n)
        push |=> entry_q[1] == $past(entry_q[0]))
        else $error("log did not shift on push");

endmodule // trip_log_mem

/* verilog/trip_response.sv */
// Trip log, trip response and fire mode, with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Keep history of ten latest trips
// - Entry one newest or active, ten oldest
// - Selector picks date/time or module stamp
// - Copy current date and time when logged
// - Time source: power-up, running, or clock
// - History reads return numeric trip code
// - Any trip disables output stage
// - Freeze monitors on trip except undervoltage
// - I/O run; outputs low on overload/aux
// - Logic functions keep running when tripped
// - Program runs unless its own trip
// - Brake runs except listed trips, LV supply
// - Fire mode enables only restricted trips
// - Fire mode disables motor overload, thermal
// - Fire mode shows flashing warning
// - Default overload 113 open, 114 closed
// - Overload threshold settable below 150
module trip_response
    import trip_pkg::*;
#(
    parameter int MON_W    = 256,
    parameter int DOUT_W   = 4,
    parameter int BLINK_CY = 20000000
) (
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    // AXI4-Lite slave
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Trip sources
    input  wire logic              TRIP_REQ,
    input  wire logic [CODE_W-1:0] TRIP_CODE,
    input  wire logic [7:0]        TRIP_MODULE,
    input  wire logic [7:0]        TRIP_PENDING_BRAKE,
    input  time_base_t             TIME_BASE,
    // Fire mode inputs
    input  wire logic [15:0]       FIRE_SPEED,
    input  wire logic              DIGITAL_IN4,
    // Monitors and I/O
    input  wire logic [MON_W-1:0]  MONITOR_LIVE,
    output logic [MON_W-1:0]       MONITOR_VIEW,
    input  wire logic [DOUT_W-1:0] DOUT_REQ,
    output logic [DOUT_W-1:0]      DOUT,
    input  wire logic              BRAKE_REQ,
    output logic                   BRAKE_ON,
    output logic                   OUTPUT_ENABLE,
    output logic                   LOGIC_RUN,
    output logic                   PROGRAM_RUN,
    output logic                   MOTOR_PROT_EN,
    output logic                   FIRE_WARN,
    output logic                   IRQ
);

    // ****************************************************************
    // Trip classification
    // ****************************************************************
    function automatic logic in_range(input logic [7:0] c,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (c >= lo) && (c <= hi);
    endfunction

    function automatic logic brake_kill(input logic [7:0] c);
        brake_kill = (c == CODE_BRAKE_OVERCUR) || (c == CODE_POWER_STAGE)
                  || (c == CODE_BRAKE_THERMAL) || (c == CODE_BUS_HIGH_V)
                  || in_range(c, CODE_HW_FAULT_LO, CODE_HW_FAULT_HI);
    endfunction

    // fire mode from speed setting and input four
    logic fire_active;
    assign fire_active = (FIRE_SPEED != 16'h0000) && DIGITAL_IN4;

    // restricted trip set in fire mode
    logic trip_allowed;
    always_comb begin
        if (fire_active) begin
            trip_allowed = (TRIP_CODE != CODE_MOTOR_OVERLD)
                        && (TRIP_CODE != CODE_MOTOR_THERMAL)
                        && (TRIP_CODE != CODE_OUT_OVERLOAD);
        end else begin
            trip_allowed = 1'b1;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [5:0]        ctrl_q;
    logic [7:0]        ovl_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_en_q;
    logic              tripped_q;
    logic [CODE_W-1:0] active_code_q;
    logic              brake_off_q;
    logic              dout_low_q;
    logic              prog_stop_q;
    logic              freeze_q;
    logic [MON_W-1:0]  mon_q;
    logic [24:0]       blink_cnt_q;
    logic              blink_q;
    logic              fire_q;

    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic trip_take;
    logic trip_clear;

    assign trip_take  = TRIP_REQ && trip_allowed && !tripped_q;
    assign trip_clear = wr_fire && (wr_addr == OFS_CTRL)
                     && wr_data[CTRL_TRIP_CLR];

    // ****************************************************************
    // Trip log
    // ****************************************************************
    log_entry_t new_entry;
    log_entry_t rd_entry;
    logic [3:0] rd_idx;

    always_comb begin
        new_entry.code = TRIP_CODE;
        if (ctrl_q[CTRL_STAMP_SEL]) begin
            new_entry.date_or_zero   = '0;
            new_entry.time_or_module = {24'h000000, TRIP_MODULE};
        end else begin
            new_entry.date_or_zero = TIME_BASE.rtc_date;
            case (ctrl_q[CTRL_TSRC_LSB +: 2])
                TSRC_POWERUP: new_entry.time_or_module = TIME_BASE.powerup;
                TSRC_RUNNING: new_entry.time_or_module = TIME_BASE.running;
                TSRC_RTC:     new_entry.time_or_module = TIME_BASE.rtc_time;
                default:      new_entry.time_or_module = TIME_BASE.powerup;
            endcase
        end
    end

    // newest trip lands in entry one
    trip_log_mem #(.DEPTH(LOG_DEPTH)) u_log (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .push      (trip_take),
        .new_entry (new_entry),
        .rd_idx    (rd_idx),
        .rd_entry  (rd_entry)
    );

    // ****************************************************************
    // Trip state
    // ****************************************************************
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tripped_q     <= 1'b0;
            active_code_q <= '0;
        end else if (trip_take) begin
            tripped_q     <= 1'b1;
            active_code_q <= TRIP_CODE;
        end else if (trip_clear) begin
            tripped_q     <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            freeze_q <= 1'b0;
            mon_q    <= '0;
        end else begin
            if (trip_take && TRIP_CODE != CODE_UNDERVOLTAGE) begin
                freeze_q <= 1'b1;
            end else if (trip_clear) begin
                freeze_q <= 1'b0;
            end
            if (!freeze_q && !(trip_take
                               && TRIP_CODE != CODE_UNDERVOLTAGE)) begin
                mon_q <= MONITOR_LIVE;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dout_low_q  <= 1'b0;
            prog_stop_q <= 1'b0;
            brake_off_q <= 1'b0;
        end else if (trip_clear) begin
            dout_low_q  <= 1'b0;
            prog_stop_q <= 1'b0;
            brake_off_q <= 1'b0;
        end else begin
            if (trip_take && (TRIP_CODE == CODE_OUT_OVERLOAD
                              || TRIP_CODE == CODE_AUX_SUPPLY)) begin
                dout_low_q <= 1'b1;
            end
            if (trip_take
                && in_range(TRIP_CODE, CODE_PROGRAM_LO, CODE_PROGRAM_HI)) begin
                prog_stop_q <= 1'b1;
            end
            if ((trip_take && brake_kill(TRIP_CODE))
                || (tripped_q && brake_kill(TRIP_PENDING_BRAKE))) begin
                brake_off_q <= 1'b1;
            end
        end
    end

    // flashing warning while fire mode active
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
            fire_q      <= 1'b0;
        end else begin
            fire_q <= fire_active;
            if (!fire_active || blink_cnt_q == 25'(BLINK_CY - 1)) begin
                blink_cnt_q <= '0;
                blink_q     <= fire_active && !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 25'd1;
            end
        end
    end

    assign OUTPUT_ENABLE = !tripped_q;
    assign MONITOR_VIEW  = mon_q;
    assign DOUT          = dout_low_q ? '0 : DOUT_REQ;
    // brake off on LV supply or listed trips
    assign BRAKE_ON      = BRAKE_REQ && !brake_off_q
                        && !ctrl_q[CTRL_LV_SUPPLY];
    assign LOGIC_RUN     = 1'b1;
    assign PROGRAM_RUN   = !prog_stop_q;
    // motor protection off in fire mode
    assign MOTOR_PROT_EN = !fire_active;
    assign FIRE_WARN     = blink_q;
    assign IRQ           = |(irq_stat_q & irq_en_q);

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;

    assign S_AXI_AWREADY = !aw_held_q && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held_q && !S_AXI_BVALID;
    assign wr_addr = aw_held_q ? aw_q : S_AXI_AWADDR;
    assign wr_data = w_held_q ? w_q : S_AXI_WDATA;
    assign wr_fire = (aw_held_q || (S_AXI_AWVALID && S_AXI_AWREADY))
                  && (w_held_q || (S_AXI_WVALID && S_AXI_WREADY));

    function automatic logic wr_mapped(input logic [7:0] a);
        wr_mapped = (a == OFS_CTRL) || (a == OFS_IRQ_EN)
                 || (a == OFS_IRQ_CLR) || (a == OFS_OVL);
    endfunction

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_q         <= '0;
            w_q          <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                    aw_held_q <= 1'b1;
                    aw_q      <= S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && S_AXI_WREADY) begin
                    w_held_q <= 1'b1;
                    w_q      <= S_AXI_WDATA;
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_q   <= CTRL_RESET;
            ovl_q    <= OVL_DEFAULT_OPEN;
            irq_en_q <= '0;
        end else if (wr_fire) begin
            if (wr_addr == OFS_CTRL) begin
                ctrl_q <= {wr_data[CTRL_LV_SUPPLY], 1'b0,
                           wr_data[CTRL_CLOSED], wr_data[2:0]};
                if (wr_data[CTRL_CLOSED] != ctrl_q[CTRL_CLOSED]) begin
                    ovl_q <= wr_data[CTRL_CLOSED] ? OVL_DEFAULT_CLOSED
                                                  : OVL_DEFAULT_OPEN;
                end
            end
            if (wr_addr == OFS_IRQ_EN) begin
                irq_en_q <= wr_data[IRQ_W-1:0];
            end
            if (wr_addr == OFS_OVL && wr_data[7:0] < OVL_LIMIT) begin
                ovl_q <= wr_data[7:0];
            end
        end
    end

    // Sticky events; a new event wins over a clear
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_set = {fire_active && !fire_q, trip_clear && tripped_q,
                      trip_take};
    assign irq_clr = (wr_fire && wr_addr == OFS_IRQ_CLR)
                   ? wr_data[IRQ_W-1:0] : '0;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_idx = S_AXI_ARADDR[5:2];

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= RESP_OKAY;
            S_AXI_RDATA  <= '0;
            if (S_AXI_ARADDR >= OFS_CODE0 && rd_idx < 4'(LOG_DEPTH)) begin
                case (S_AXI_ARADDR[7:6])
                    2'h1: S_AXI_RDATA <= {24'h000000, rd_entry.code};
                    2'h2: S_AXI_RDATA <= rd_entry.date_or_zero;
                    default: S_AXI_RDATA <= rd_entry.time_or_module;
                endcase
            end else begin
                case (S_AXI_ARADDR)
                    OFS_CTRL:     S_AXI_RDATA <= {26'h0, ctrl_q};
                    OFS_STATUS:   S_AXI_RDATA <= {16'h0, active_code_q,
                                    2'h0, fire_active, brake_off_q,
                                    prog_stop_q, dout_low_q, freeze_q,
                                    tripped_q};
                    OFS_IRQ_STAT: S_AXI_RDATA <= {29'h0, irq_stat_q};
                    OFS_IRQ_EN:   S_AXI_RDATA <= {29'h0, irq_en_q};
                    OFS_IRQ_CLR:  S_AXI_RDATA <= '0;
                    OFS_OVL:      S_AXI_RDATA <= {24'h0, ovl_q};
                    default:      S_AXI_RRESP <= RESP_SLVERR;
                endcase
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_trip_disable: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        trip_take |=> !OUTPUT_ENABLE) else $error("output not off");
    a_mon_freeze: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        freeze_q && !trip_clear |=> $stable(MONITOR_VIEW))
        else $error("monitor moved while frozen");
    a_dout_low: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        trip_take && (TRIP_CODE == CODE_AUX_SUPPLY
                      || TRIP_CODE == CODE_OUT_OVERLOAD) |=> DOUT == '0)
        else $error("outputs not low");
    a_brake_kill: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        trip_take && brake_kill(TRIP_CODE) |=> !BRAKE_ON)
        else $error("brake still on");
    a_fire_prot: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        fire_active |-> !MOTOR_PROT_EN) else $error("prot on");
    a_fire_filter: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        fire_active && TRIP_REQ && !tripped_q
        && (TRIP_CODE == CODE_MOTOR_OVERLD || TRIP_CODE == CODE_OUT_OVERLOAD
            || TRIP_CODE == CODE_MOTOR_THERMAL) |=> !tripped_q)
        else $error("trip in fire");
    a_ovl_cap: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        ovl_q < OVL_LIMIT) else $error("threshold over cap");
    a_prog_run: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        trip_take && TRIP_CODE == CODE_UNDERVOLTAGE |=> PROGRAM_RUN)
        else $error("program stopped");

endmodule // trip_response

/* bench/fire_cmd_model.sv */
// Operator model commanding fire mode
`timescale 1ns/1ps
module fire_cmd_model (
    input  wire logic   fire_on,
    output logic [15:0] fspeed,
    output logic        din4
);
    assign {fspeed, din4} = fire_on ? 17'h00201 : 17'h00000;
endmodule // fire_cmd_model

/* bench/tb.sv */
// Trip block bench
`timescale 1ns/1ps
module tb;
    import trip_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, bry = 0, rry = 0;
    logic trip = 0, fire = 0, awr, wrd, bv, arr, rv, oe, brk, lrun, prun;
    logic prot, fw, irq, d4, ta, tw, tv, breq = 1;
    logic [7:0] awa = 0, ara = 0, tc = 0, pb = 0;
    logic [31:0] wd = 0, ml = 0, rdat, rdv, mv, v1;
    logic [15:0] fs;
    logic [3:0] dout, dreq = 4'hF;
    logic [1:0] br, rr, rsp;
    int failures = 0, comparisons = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) ml <= ml + 32'h1;
    fire_cmd_model u_fire (.fire_on(fire), .fspeed(fs), .din4(d4));
    trip_response #(.MON_W(32), .DOUT_W(4), .BLINK_CY(4)) u_dut (
        .CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .TRIP_REQ(trip), .TRIP_CODE(tc), .TRIP_MODULE(~tc),
        .TRIP_PENDING_BRAKE(pb), .FIRE_SPEED(fs), .DIGITAL_IN4(d4),
        .TIME_BASE({32'h11, 32'h22, 32'h33, 32'h44}), .MONITOR_LIVE(ml),
        .MONITOR_VIEW(mv), .DOUT_REQ(dreq), .DOUT(dout), .BRAKE_REQ(breq),
        .BRAKE_ON(brk), .OUTPUT_ENABLE(oe), .LOGIC_RUN(lrun),
        .PROGRAM_RUN(prun), .MOTOR_PROT_EN(prot), .FIRE_WARN(fw), .IRQ(irq));
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        failures += (s !== e);
        if (s !== e) $display("[ERR] %s exp %h got %h", n, e, s);
    endtask
    task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {awa, ara, wd, awv, wv, bry, arv, rry} <= {a, a, d, w, w, w, !w, !w};
        do begin
            @(negedge clk) {ta, tw, tv} = {awv & awr | arv & arr, wv & wrd, bv | rv};
            {rsp, rdv} = {w ? br : rr, rdat};
            @(posedge clk) {awv, wv, arv} <= {awv & ~ta, wv & ~tw, arv & ~ta};
        end while (!tv);
        {bry, rry} <= 2'b00;
        if (!w) chk("rd", rdv, d);
        @(negedge clk);
    endtask
    task automatic hit(input logic [7:0] c);
        @(posedge clk) {trip, tc} <= {1'b1, c};
        @(posedge clk) trip <= 1'b0;
        @(negedge clk) v1 = mv;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_trip;
        bus(1'b1, OFS_IRQ_EN, 32'h1);
        hit(CODE_OUT_OVERLOAD);
        chk("out", {oe, dout}, 5'h00);
        chk("run", {lrun, prun}, 2'b11);
        chk("view", mv, v1);
        chk("irq", irq, 1'b1);
        bus(1'b0, OFS_CODE0, 32'(CODE_OUT_OVERLOAD));
        bus(1'b1, OFS_IRQ_CLR, 32'h1);
        chk("irq", irq, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h11);
    endtask
    task automatic t_shift;
        hit(CODE_POWER_STAGE);
        chk("brk", brk, 1'b0);
        bus(1'b0, OFS_TIME0, {24'h0, ~CODE_POWER_STAGE});
        bus(1'b1, OFS_CTRL, 32'h14);
        hit(CODE_UNDERVOLTAGE);
        chk("live", mv !== v1, 1'b1);
        bus(1'b0, OFS_DATE0, 32'h44);
        bus(1'b0, OFS_TIME0, 32'h33);
        bus(1'b0, OFS_CODE0 + 8'h08, 32'(CODE_OUT_OVERLOAD));
        bus(1'b1, OFS_CTRL, 32'h12);
    endtask
    task automatic t_fire;
        @(posedge clk) fire <= 1'b1;
        hit(CODE_OUT_OVERLOAD);
        chk("prot", prot, 1'b0);
        chk("oe", oe, 1'b1);
        ta = fw;
        repeat (4) @(negedge clk);
        chk("warn", fw, !ta);
        @(posedge clk) fire <= 1'b0;
        repeat (2) @(negedge clk);
        chk("off", {fw, prot}, 2'b01);
    endtask
    task automatic t_ovl;
        bus(1'b1, OFS_OVL, 32'h96);
        bus(1'b0, OFS_OVL, 32'(OVL_DEFAULT_OPEN));
        bus(1'b1, OFS_CTRL, 32'h08);
        bus(1'b0, OFS_CTRL, 32'h08);
        bus(1'b0, OFS_OVL, 32'(OVL_DEFAULT_CLOSED));
        bus(1'b1, OFS_OVL, 32'h95);
        bus(1'b0, OFS_OVL, 32'h95);
        bus(1'b1, 8'hFC, 32'h1);
        chk("bresp", rsp, 32'(RESP_SLVERR));
        bus(1'b0, 8'hFC, 32'h0);
        chk("rresp", rsp, 32'(RESP_SLVERR));
    endtask
    task automatic t_prog;
        bus(1'b0, OFS_IRQ_STAT, 32'h7);
        @(posedge clk) dreq <= 4'h5;
        hit(CODE_PROGRAM_LO);
        chk("prog", {prun, brk, dout}, 6'h15);
        bus(1'b0, OFS_TIME0, 32'h22);
        @(posedge clk) pb <= CODE_BUS_HIGH_V;
        repeat (2) @(negedge clk);
        chk("pend", brk, 1'b0);
        bus(1'b0, OFS_STATUS, {16'h0, CODE_PROGRAM_LO, 8'h1B});
        bus(1'b1, OFS_CTRL, 32'h10);
        chk("clr", {brk, prun}, 2'b11);
        bus(1'b1, OFS_CTRL, 32'h20);
        chk("lv", brk, 1'b0);
    endtask
    task automatic close_out;
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_ovl;
        t_trip;
        t_shift;
        t_fire;
        t_prog;
        close_out;
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule // tb
